// file: cis_pkg.sv
package cis_pkg;

    localparam int unsigned CODE_W         = 5;
    localparam int unsigned FIELDS_PER_REG = 6;
    localparam int unsigned N_ROUTED       = 12;
    localparam int unsigned N_CPU_INT      = 16;
    localparam int unsigned N_SRC          = 32;
    localparam int unsigned GAP_SLOT       = 3;

    localparam logic [31:0] ADDR_SEL_HIGH  = 32'h019C0000;
    localparam logic [31:0] ADDR_SEL_LOW   = 32'h019C0004;
    localparam logic [31:0] ADDR_STATUS    = 32'h019C0008;
    localparam logic [31:0] ADDR_MASK      = 32'h019C000C;
    localparam logic [31:0] SEL_WR_MASK    = 32'h7FFF7FFF;

    localparam logic [4:0] CODE_HOST_DSP   = 5'h00;
    localparam logic [4:0] CODE_TIMER0     = 5'h01;
    localparam logic [4:0] CODE_TIMER1     = 5'h02;
    localparam logic [4:0] CODE_SDRAM_A    = 5'h03;
    localparam logic [4:0] CODE_GPIO4      = 5'h04;
    localparam logic [4:0] CODE_GPIO5      = 5'h05;
    localparam logic [4:0] CODE_GPIO6      = 5'h06;
    localparam logic [4:0] CODE_GPIO7      = 5'h07;
    localparam logic [4:0] CODE_DMA_DONE   = 5'h08;
    localparam logic [4:0] CODE_EMU_DMA    = 5'h09;
    localparam logic [4:0] CODE_EMU_RX     = 5'h0A;
    localparam logic [4:0] CODE_EMU_TX     = 5'h0B;
    localparam logic [4:0] CODE_SER0_TX    = 5'h0C;
    localparam logic [4:0] CODE_SER0_RX    = 5'h0D;
    localparam logic [4:0] CODE_SER1_TX    = 5'h0E;
    localparam logic [4:0] CODE_SER1_RX    = 5'h0F;
    localparam logic [4:0] CODE_GPIO0      = 5'h10;
    localparam logic [4:0] CODE_SER2_TX    = 5'h11;
    localparam logic [4:0] CODE_SER2_RX    = 5'h12;
    localparam logic [4:0] CODE_TIMER2     = 5'h13;
    localparam logic [4:0] CODE_SDRAM_B    = 5'h14;
    localparam logic [4:0] CODE_RES_A      = 5'h15;
    localparam logic [4:0] CODE_RES_B      = 5'h16;
    localparam logic [4:0] CODE_UTOPIA     = 5'h17;
    localparam logic [4:0] CODE_RES_LO     = 5'h18;
    localparam logic [4:0] CODE_RES_HI     = 5'h1D;
    localparam logic [4:0] CODE_VITERBI    = 5'h1E;
    localparam logic [4:0] CODE_TURBO      = 5'h1F;

    localparam logic [31:0] SEL_LOW_RESET  = {1'b0, CODE_EMU_DMA, CODE_DMA_DONE, CODE_GPIO7,
                                              1'b0, CODE_GPIO6, CODE_GPIO5, CODE_GPIO4};
    localparam logic [31:0] SEL_HIGH_RESET = {1'b0, CODE_TIMER1, CODE_TIMER0, CODE_HOST_DSP,
                                              1'b0, CODE_EMU_TX, CODE_EMU_RX, CODE_SDRAM_A};
    localparam logic [11:0] STATUS_RESET   = 12'h000;
    localparam logic [11:0] MASK_RESET     = 12'h000;
    localparam logic [3:0]  PRIO_RESET     = 4'h0;

    typedef struct packed {
        logic line;
    } cis_route_state_t;

    typedef struct packed {
        logic [31:0] sel_low;
        logic [31:0] sel_high;
        logic [11:0] status;
        logic [11:0] mask;
        logic        rst_line;
        logic        nmi_line;
        logic [31:0] prdata;
        logic        slverr;
        logic [3:0]  prio;
        logic        prio_valid;
    } cis_state_t;

    function automatic logic is_reserved(input logic [4:0] code);
        return (code == CODE_RES_A) || (code == CODE_RES_B) ||
               ((code >= CODE_RES_LO) && (code <= CODE_RES_HI));
    endfunction : is_reserved

    // fields above the gap sit one bit higher
    function automatic int unsigned field_lsb(input int unsigned slot);
        return slot * CODE_W + ((slot >= GAP_SLOT) ? 1 : 0);
    endfunction : field_lsb

    function automatic logic [4:0] field_code(input logic [31:0] low,
                                              input logic [31:0] high,
                                              input int unsigned n);
        logic [31:0] w;
        w = (n < FIELDS_PER_REG) ? low : high;
        return w[field_lsb(n % FIELDS_PER_REG) +: CODE_W];
    endfunction : field_code

endpackage : cis_pkg

// file: cis_route.sv
`timescale 1ns/10ps
module cis_route (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [31:0] sources,
    input  wire logic [4:0]  code,
    output logic             line
);
    cis_pkg::cis_route_state_t st;
    cis_pkg::cis_route_state_t next_st;

    always_comb begin
        next_st = st;
        // pick the coded source, reserved codes stay quiet
        next_st.line = sources[code] & ~cis_pkg::is_reserved(code);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign line = st.line;

    ////////////////////////////////////////////////////////////////////////////////
    a_route_follow: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> (line == ($past(sources[code]) && !cis_pkg::is_reserved($past(code)))))
        else $error("routed line does not follow selected source");

    a_reserved_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        cis_pkg::is_reserved(code) |=> !line)
        else $error("reserved code drove a line");

endmodule : cis_route

// file: cis_selector.sv
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/10ps
module cis_selector (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        reset_request,
    input  wire logic        nmi_request,
    input  wire logic        host_dsp_event,
    input  wire logic        timer_zero_event,
    input  wire logic        timer_one_event,
    input  wire logic        timer_two_event,
    input  wire logic        sdram_a_refresh_event,
    input  wire logic        sdram_b_refresh_event,
    input  wire logic        gpio_pin0_event,
    input  wire logic        gpio_pin4_event,
    input  wire logic        gpio_pin5_event,
    input  wire logic        gpio_pin6_event,
    input  wire logic        gpio_pin7_event,
    input  wire logic        dma_done_event,
    input  wire logic        emulation_dma_event,
    input  wire logic        emu_exchange_rx_event,
    input  wire logic        emu_exchange_tx_event,
    input  wire logic        serial0_tx_event,
    input  wire logic        serial0_rx_event,
    input  wire logic        serial1_tx_event,
    input  wire logic        serial1_rx_event,
    input  wire logic        serial2_tx_event,
    input  wire logic        serial2_rx_event,
    input  wire logic        utopia_event,
    input  wire logic        viterbi_copro_event,
    input  wire logic        turbo_copro_event,
    output logic [15:0]      cpu_int,
    output logic [3:0]       highest_pending,
    output logic             pending_valid,
    output logic             irq
);
    cis_pkg::cis_state_t st;
    cis_pkg::cis_state_t next_st;
    logic [31:0]         sources;
    logic [11:0]         route_line;
    logic                setup;
    logic                wr_access;
    logic                hit_high;
    logic                hit_low;
    logic                hit_status;
    logic                hit_mask;

    ////////////////////////////////////////////////////////////////////////////////
    // source vector indexed by selector code; reserved codes are tied low
    always_comb begin
        sources                              = '0;
        sources[cis_pkg::CODE_HOST_DSP]      = host_dsp_event;
        sources[cis_pkg::CODE_TIMER0]        = timer_zero_event;
        sources[cis_pkg::CODE_TIMER1]        = timer_one_event;
        sources[cis_pkg::CODE_SDRAM_A]       = sdram_a_refresh_event;
        sources[cis_pkg::CODE_GPIO4]         = gpio_pin4_event;
        sources[cis_pkg::CODE_GPIO5]         = gpio_pin5_event;
        sources[cis_pkg::CODE_GPIO6]         = gpio_pin6_event;
        sources[cis_pkg::CODE_GPIO7]         = gpio_pin7_event;
        sources[cis_pkg::CODE_DMA_DONE]      = dma_done_event;
        sources[cis_pkg::CODE_EMU_DMA]       = emulation_dma_event;
        sources[cis_pkg::CODE_EMU_RX]        = emu_exchange_rx_event;
        sources[cis_pkg::CODE_EMU_TX]        = emu_exchange_tx_event;
        sources[cis_pkg::CODE_SER0_TX]       = serial0_tx_event;
        sources[cis_pkg::CODE_SER0_RX]       = serial0_rx_event;
        sources[cis_pkg::CODE_SER1_TX]       = serial1_tx_event;
        sources[cis_pkg::CODE_SER1_RX]       = serial1_rx_event;
        sources[cis_pkg::CODE_GPIO0]         = gpio_pin0_event;
        sources[cis_pkg::CODE_SER2_TX]       = serial2_tx_event;
        sources[cis_pkg::CODE_SER2_RX]       = serial2_rx_event;
        sources[cis_pkg::CODE_TIMER2]        = timer_two_event;
        sources[cis_pkg::CODE_SDRAM_B]       = sdram_b_refresh_event;
        sources[cis_pkg::CODE_UTOPIA]        = utopia_event;
        sources[cis_pkg::CODE_VITERBI]       = viterbi_copro_event;
        sources[cis_pkg::CODE_TURBO]         = turbo_copro_event;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one routing stage per maskable line, each fed by its own field
    for (genvar i = 0; i < cis_pkg::N_ROUTED; i++) begin : g_route
        cis_route u_route (
            .pclk    (pclk),
            .presetn (presetn),
            .sources (sources),
            .code    (cis_pkg::field_code(st.sel_low, st.sel_high, i)),
            .line    (route_line[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    // address decode on the full byte address
    assign hit_high   = (paddr == cis_pkg::ADDR_SEL_HIGH);
    assign hit_low    = (paddr == cis_pkg::ADDR_SEL_LOW);
    assign hit_status = (paddr == cis_pkg::ADDR_STATUS);
    assign hit_mask   = (paddr == cis_pkg::ADDR_MASK);
    assign setup      = psel & ~penable;
    // read data and error are prepared in setup so the access phase needs no wait
    assign wr_access  = psel & penable & pwrite;

    always_comb begin
        next_st = st;
        // fixed lines follow their own requests, never a selector
        next_st.rst_line = reset_request;
        next_st.nmi_line = nmi_request;
        if (setup) begin
            next_st.slverr = ~(hit_high | hit_low | hit_status | hit_mask);
            unique case (1'b1)
                hit_high:   next_st.prdata = st.sel_high;
                hit_low:    next_st.prdata = st.sel_low;
                hit_status: next_st.prdata = {20'h00000, st.status};
                hit_mask:   next_st.prdata = {20'h00000, st.mask};
                default:    next_st.prdata = 32'h00000000;
            endcase
        end
        // gap bits and bit 31 never take a write
        if (wr_access && hit_high) begin
            next_st.sel_high = pwdata & cis_pkg::SEL_WR_MASK;
        end
        if (wr_access && hit_low) begin
            next_st.sel_low = pwdata & cis_pkg::SEL_WR_MASK;
        end
        if (wr_access && hit_mask) begin
            next_st.mask = pwdata[11:0];
        end
        // a set in the same cycle as its write-one clear wins
        next_st.status = st.status & ~((wr_access && hit_status) ? pwdata[11:0] : 12'h000);
        next_st.status = next_st.status | route_line;
        // lowest-numbered active line has highest priority
        next_st.prio_valid = |cpu_int;
        next_st.prio       = cis_pkg::PRIO_RESET;
        for (int j = cis_pkg::N_CPU_INT - 1; j >= 0; j--) begin
            if (cpu_int[j]) begin
                next_st.prio = 4'(j);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st            <= '0;
            st.sel_low    <= cis_pkg::SEL_LOW_RESET;
            st.sel_high   <= cis_pkg::SEL_HIGH_RESET;
            st.status     <= cis_pkg::STATUS_RESET;
            st.mask       <= cis_pkg::MASK_RESET;
        end else begin
            st <= next_st;
        end
    end

    // lines 2 and 3 are reserved and held low
    assign cpu_int         = {route_line, 2'b00, st.nmi_line, st.rst_line};
    assign prdata          = st.prdata;
    assign pready          = 1'b1;
    assign pslverr         = st.slverr & psel & penable;
    assign highest_pending = st.prio;
    assign pending_valid   = st.prio_valid;
    assign irq             = |(st.status & st.mask);

    ////////////////////////////////////////////////////////////////////////////////
    logic [15:0] cpu_int_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_int_d <= 16'h0000;
        end else begin
            cpu_int_d <= cpu_int;
        end
    end

    a_fixed_lines: assert property (@(posedge pclk) disable iff (!presetn)
        (cpu_int[3:2] == 2'b00) and (nmi_request |=> cpu_int[1]))
        else $error("fixed lines misbehave");

    a_write_low: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_access && hit_low) |=> (st.sel_low == ($past(pwdata) & cis_pkg::SEL_WR_MASK)))
        else $error("low selector write lost");

    a_write_high: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_access && hit_high) |=> (st.sel_high == ($past(pwdata) & cis_pkg::SEL_WR_MASK)))
        else $error("high selector write lost");

    a_gap_zero: assert property (@(posedge pclk) disable iff (!presetn)
        !st.sel_low[15] && !st.sel_low[31] && !st.sel_high[15] && !st.sel_high[31])
        else $error("unused selector bit set");

    a_sticky_set: assert property (@(posedge pclk) disable iff (!presetn)
        (route_line != 12'h000) |=> ((st.status & $past(route_line)) == $past(route_line)))
        else $error("event lost from status");

    a_prio_order: assert property (@(posedge pclk) disable iff (!presetn)
        pending_valid |-> (cpu_int_d[highest_pending] &&
                           ((cpu_int_d & ((16'h0001 << highest_pending) - 16'h0001)) == 16'h0000)))
        else $error("priority not lowest active line");

    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !(hit_high || hit_low || hit_status || hit_mask)) |=> (penable |-> pslverr))
        else $error("unmapped access not flagged");

    a_read_low: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && hit_low) |=> (prdata == $past(st.sel_low)))
        else $error("low selector read wrong");

endmodule : cis_selector

// file: cis_cpu_model.sv
`timescale 1ns/10ps
module cis_cpu_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] cpu_int,
    output logic [3:0]       take_num,
    output logic             take_valid
);
    ////////////////////////////////////////////////////////////////////////////////////////////
    // lowest number wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            take_num   <= 4'h0;
            take_valid <= 1'b0;
        end else begin
            take_valid <= |cpu_int;
            take_num   <= 4'h0;
            for (int n = 15; n >= 0; n--) begin
                if (cpu_int[n]) begin
                    take_num <= 4'(n);
                end
            end
        end
    end
endmodule : cis_cpu_model

// file: cis_selector_tb.sv
`timescale 1ns/10ps
module cis_selector_tb;
    localparam logic [31:0] A_HIGH = 32'h019C0000;
    localparam logic [31:0] A_LOW  = 32'h019C0004;
    localparam logic [4:0]  DFLT [12] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
                                          5'h03, 5'h0A, 5'h0B, 5'h00, 5'h01, 5'h02};
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        reset_request;
    logic        nmi_request;
    logic [31:0] src;
    logic [15:0] cpu_int;
    logic [3:0]  highest_pending;
    logic        pending_valid;
    logic        irq;
    logic [3:0]  take_num;
    logic        take_valid;
    logic [31:0] rd;
    logic        err;
    logic [31:0] wv;
    int          fail_count;
    int          checks_done;
    int          cycles;

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    cis_selector i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reset_request(reset_request), .nmi_request(nmi_request),
        .host_dsp_event(src[0]), .timer_zero_event(src[1]), .timer_one_event(src[2]),
        .sdram_a_refresh_event(src[3]), .gpio_pin4_event(src[4]), .gpio_pin5_event(src[5]),
        .gpio_pin6_event(src[6]), .gpio_pin7_event(src[7]), .dma_done_event(src[8]),
        .emulation_dma_event(src[9]), .emu_exchange_rx_event(src[10]),
        .emu_exchange_tx_event(src[11]), .serial0_tx_event(src[12]),
        .serial0_rx_event(src[13]), .serial1_tx_event(src[14]), .serial1_rx_event(src[15]),
        .gpio_pin0_event(src[16]), .serial2_tx_event(src[17]), .serial2_rx_event(src[18]),
        .timer_two_event(src[19]), .sdram_b_refresh_event(src[20]), .utopia_event(src[23]),
        .viterbi_copro_event(src[30]), .turbo_copro_event(src[31]), .cpu_int(cpu_int),
        .highest_pending(highest_pending), .pending_valid(pending_valid), .irq(irq));

    cis_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .cpu_int(cpu_int),
                         .take_num(take_num), .take_valid(take_valid));

    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // holds the request until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values;
        apb(1'b0, A_HIGH, 32'h0);
        chk(rd, 32'h08202D43);
        apb(1'b0, A_LOW, 32'h0);
        chk(rd, 32'h250718A4);
        chk({31'h0, irq}, 32'h0);
    endtask : t_reset_values

    task automatic t_default_routing;
        for (int i = 0; i < 12; i++) begin
            src <= 32'h1 << DFLT[i];
            cyc(3);
            chk({16'h0, cpu_int}, 32'h10 << i);
            chk({28'h0, highest_pending}, 32'(i + 4));
            chk({28'h0, highest_pending}, {28'h0, take_num});
            chk({31'h0, pending_valid}, 32'h1);
            chk({31'h0, take_valid}, 32'h1);
        end
        src <= 32'h0;
        cyc(3);
        chk({31'h0, pending_valid}, 32'h0);
        chk({31'h0, take_valid}, 32'h0);
    endtask : t_default_routing

    task automatic t_fixed_lines;
        src           <= 32'hFFFFFFFF;
        reset_request <= 1'b1;
        nmi_request   <= 1'b1;
        cyc(3);
        chk({16'h0, cpu_int}, 32'h0000FFF3);
        chk({28'h0, highest_pending}, 32'h0);
        reset_request <= 1'b0;
        cyc(3);
        chk({28'h0, highest_pending}, 32'h1);
        nmi_request <= 1'b0;
        src         <= 32'h0;
        cyc(3);
    endtask : t_fixed_lines

    task automatic t_interrupts;
        apb(1'b0, cis_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h00000FFF);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, cis_pkg::ADDR_MASK, 32'h00000FFF);
        cyc(1);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, cis_pkg::ADDR_STATUS, 32'h00000FFF);
        cyc(1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, cis_pkg::ADDR_MASK, 32'h00000001);
        src <= 32'h1 << 5;
        cyc(3);
        src <= 32'h0;
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, cis_pkg::ADDR_STATUS, 32'h0);
        chk(rd, 32'h00000002);
        src <= 32'h1 << 4;
        cyc(3);
        src <= 32'h0;
        chk({31'h0, irq}, 32'h1);
        cyc(2);
        apb(1'b1, cis_pkg::ADDR_STATUS, 32'h00000003);
        cyc(1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b0, cis_pkg::ADDR_MASK, 32'h0);
        chk(rd, 32'h00000001);
    endtask : t_interrupts

    task automatic t_reprogram;
        src <= 32'h1 << 4;
        // normal programming uses listed codes only
        wv  = {1'b1, {3{5'h14}}, 1'b1, {3{5'h14}}};
        apb(1'b1, A_LOW, wv);
        chk({31'h0, err}, 32'h0);
        cyc(2);
        chk({31'h0, cpu_int[4]}, 32'h0);
        // reserved codes only here, to prove the lines stay quiet
        apb(1'b1, A_HIGH, {1'b1, {3{5'h15}}, 1'b1, 5'h16, 5'h18, 5'h1D});
        apb(1'b0, A_LOW, 32'h0);
        chk(rd, wv & 32'h7FFF7FFF);
        src <= 32'h1 << 20;
        cyc(3);
        chk({16'h0, cpu_int}, 32'h000003F0);
        src <= 32'hFFFFFFFF;
        cyc(3);
        chk({16'h0, cpu_int}, 32'h000003F0);
        src <= 32'h0;
        apb(1'b1, 32'h019C0010, 32'hFFFFFFFF);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 32'h019C0010, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask : t_reprogram

    ////////////////////////////////////////////////////////////////////////////////////////////
    // hang guard, far above the roughly 115 cycles the run needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            print_verdict();
        end
    end

    initial begin
        presetn       = 1'b0;
        psel          = 1'b0;
        penable       = 1'b0;
        pwrite        = 1'b0;
        paddr         = 32'h0;
        pwdata        = 32'h0;
        reset_request = 1'b0;
        nmi_request   = 1'b0;
        src           = 32'h0;
        fail_count    = 0;
        checks_done   = 0;
        cycles        = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_default_routing();
        t_fixed_lines();
        t_interrupts();
        t_reprogram();
        print_verdict();
    end
endmodule : cis_selector_tb
